//--- verilog/olcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module olcr_regs
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  input  wire olcr_pkg::olcr_req_t   i_req,
  input  wire logic                  i_out_en,
  input  wire logic                  i_e1_mode,
  input  wire olcr_pkg::olcr_byte_t  i_ais_det,
  output olcr_pkg::olcr_byte_t       o_rdata,
  output olcr_pkg::olcr_ctrl_t       o_ctrl,
  output olcr_pkg::olcr_crit_t [7:0] o_crit,
  output olcr_pkg::olcr_bank_t       o_bank,
  output logic [2:0]                 o_test_chan,
  output logic                       o_irq
);
  import olcr_pkg::*;

  // ==========================================================
  // storage
  olcr_byte_t rail_q;
  olcr_byte_t lcode_q;
  olcr_byte_t rxpd_q;
  olcr_byte_t txpd_q;
  olcr_byte_t exz_q;
  olcr_byte_t cvdis_q;
  olcr_byte_t crit_q;
  olcr_byte_t gcfg_q;
  olcr_byte_t float_q;
  olcr_byte_t aie_q;
  olcr_byte_t bank_q;
  olcr_byte_t rdata_q;
  olcr_byte_t rdata_d;
  olcr_byte_t ais_stat;
  olcr_byte_t ail_lat;
  olcr_byte_t ail_clr;
  logic [NCH-1:0] chm;

  // ==========================================================
  // bank decode
  wire is_pri   = (bank_q == BP_PRI);
  wire is_sec   = (bank_q == BP_SEC);
  wire is_ind   = (bank_q == BP_IND);
  wire is_bert  = (bank_q == BP_BERT);
  wire is_gtest = (bank_q == BP_GTEST);
  wire is_cht   = |chm;

  genvar k;
  generate
    for (k = 0; k < NCH; k++)
    begin : g_chm
      assign chm[k] = (bank_q == BP_CHTEST[k]);
    end
  endgenerate

  assign o_bank = is_pri   ? BANK_PRI    :
                  is_sec   ? BANK_SEC    :
                  is_ind   ? BANK_IND    :
                  is_bert  ? BANK_BERT   :
                  is_gtest ? BANK_GTEST  :
                  is_cht   ? BANK_CHTEST :
                             BANK_NONE;

  // channel index of the selected test bank, zero based
  assign o_test_chan[0] = chm[1] | chm[3] | chm[5] | chm[7];
  assign o_test_chan[1] = chm[2] | chm[3] | chm[6] | chm[7];
  assign o_test_chan[2] = chm[4] | chm[5] | chm[6] | chm[7];

  // ==========================================================
  // address decode
  wire at_rail  = is_sec & (i_req.addr == OFF_RAIL);
  wire at_lcode = is_sec & (i_req.addr == OFF_LCODE);
  wire at_rxpd  = is_sec & (i_req.addr == OFF_RXPD);
  wire at_txpd  = is_sec & (i_req.addr == OFF_TXPD);
  wire at_exz   = is_sec & (i_req.addr == OFF_EXZ);
  wire at_cvdis = is_sec & (i_req.addr == OFF_CVDIS);
  wire at_crit  = is_pri & (i_req.addr == OFF_CRIT);
  wire at_gcfg  = is_pri & (i_req.addr == OFF_GCFG);
  wire at_float = is_pri & (i_req.addr == OFF_FLOAT);
  wire at_ais   = is_pri & (i_req.addr == OFF_AIS);
  wire at_aie   = is_pri & (i_req.addr == OFF_AIE);
  wire at_ail   = is_pri & (i_req.addr == OFF_AIL);
  // pointer stays reachable whatever bank is selected
  wire at_bank  = (i_req.addr == OFF_BANK);

  wire wr_en = i_req.wr & i_ce;
  wire rd_en = i_req.rd & i_ce;

  // ==========================================================
  // read-clear and enable-clear of the alarm latches
  wire clr_rd = rd_en & at_ail;
  wire clr_ie = wr_en & at_aie;

  assign ail_clr = ({NCH{clr_rd}}) |
                   ({NCH{clr_ie}} & aie_q & ~i_req.wdata);

  // ==========================================================
  // register writes
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rail_q  <= RST_REG;
      lcode_q <= RST_REG;
      rxpd_q  <= RST_REG;
      txpd_q  <= RST_REG;
      exz_q   <= RST_REG;
      cvdis_q <= RST_REG;
      crit_q  <= RST_REG;
      gcfg_q  <= RST_REG;
      float_q <= RST_REG;
      aie_q   <= RST_REG;
      bank_q  <= RST_REG;
    end
    else if (wr_en)
    begin
      if (at_rail)
        rail_q <= i_req.wdata;
      if (at_lcode)
        lcode_q <= i_req.wdata;
      if (at_rxpd)
        rxpd_q <= i_req.wdata;
      if (at_txpd)
        txpd_q <= i_req.wdata;
      if (at_exz)
        exz_q <= i_req.wdata;
      if (at_cvdis)
        cvdis_q <= i_req.wdata;
      if (at_crit)
        crit_q <= i_req.wdata;
      if (at_gcfg)
        gcfg_q <= i_req.wdata;
      if (at_float)
        float_q <= i_req.wdata;
      if (at_aie)
        aie_q <= i_req.wdata;
      if (at_bank)
        bank_q <= i_req.wdata;
    end
  end

  // ==========================================================
  // read path: status and latch sampled before any read-clear
  assign rdata_d = ({8{at_rail}}  & rail_q)   |
                   ({8{at_lcode}} & lcode_q)  |
                   ({8{at_rxpd}}  & rxpd_q)   |
                   ({8{at_txpd}}  & txpd_q)   |
                   ({8{at_exz}}   & exz_q)    |
                   ({8{at_cvdis}} & cvdis_q)  |
                   ({8{at_crit}}  & crit_q)   |
                   ({8{at_gcfg}}  & gcfg_q)   |
                   ({8{at_float}} & float_q)  |
                   ({8{at_ais}}   & ais_stat) |
                   ({8{at_aie}}   & aie_q)    |
                   ({8{at_ail}}   & ail_lat)  |
                   ({8{at_bank}}  & bank_q);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rdata_q <= RST_REG;
    else if (rd_en)
      rdata_q <= rdata_d;
  end

  assign o_rdata = rdata_q;

  // ==========================================================
  // per-channel alarm status and interrupt latch
  generate
    for (k = 0; k < NCH; k++)
    begin : g_alarm
      olcr_alarm_chan u_alarm
      (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_ce     (i_ce),
        .i_det    (i_ais_det[k]),
        .i_ie     (aie_q[k]),
        .i_clr    (ail_clr[k]),
        .o_status (ais_stat[k]),
        .o_latch  (ail_lat[k])
      );
    end
  endgenerate

  assign o_irq = |ail_lat;

  // ==========================================================
  // effective channel controls
  // global code bit overrides both line code and violation disable
  wire        code_ovr = gcfg_q[GCFG_CODE_BIT];
  olcr_byte_t ami_eff;

  assign ami_eff = code_ovr ? ALL_ONES : lcode_q;

  // pin low floats every transmitter regardless of the register
  assign o_ctrl.tx_float    = i_out_en ? float_q : ALL_ONES;
  assign o_ctrl.single_rail = rail_q;
  assign o_ctrl.ami         = ami_eff;
  assign o_ctrl.rx_pd       = rxpd_q;
  assign o_ctrl.tx_pd       = txpd_q;
  assign o_ctrl.exz_en      = exz_q & rail_q & ~ami_eff;
  // hdb3 only exists in e1 mode, so t1 keeps violation detect off
  assign o_ctrl.cv_en       = ~cvdis_q & rail_q & ~ami_eff &
                              {8{i_e1_mode}};

  generate
    for (k = 0; k < NCH; k++)
    begin : g_crit
      assign o_crit[k] = !i_e1_mode ? CRIT_T1231 :
                         crit_q[k]  ? CRIT_ETSI  :
                                      CRIT_G775;
    end
  endgenerate

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_PIN_FLOATS_ALL:
    assert property (!i_out_en |-> o_ctrl.tx_float == ALL_ONES)
    else $error("pin low did not float all transmitters");

  AST_FLOAT_REG:
    assert property (i_out_en |-> o_ctrl.tx_float == float_q)
    else $error("float output differs from register");

  AST_BANK_WRITE:
    assert property (wr_en && at_bank |=> bank_q == $past(i_req.wdata))
    else $error("bank pointer not written");

  AST_SEC_BANK:
    assert property (bank_q == BP_SEC |-> o_bank == BANK_SEC)
    else $error("secondary bank not decoded");

  AST_CH8_TEST:
    assert property (bank_q == BP_CHTEST[NCH-1] |-> o_bank == BANK_CHTEST &&
                     o_test_chan == 3'h7)
    else $error("channel 8 test bank not decoded");

  AST_RAIL_WRITE:
    assert property (wr_en && at_rail |=> o_ctrl.single_rail ==
                     $past(i_req.wdata))
    else $error("rail select not applied");

  AST_CODE_OVERRIDE:
    assert property (code_ovr |-> o_ctrl.ami == ALL_ONES &&
                     o_ctrl.cv_en == RST_REG)
    else $error("global code did not force ami");

  AST_EXZ_GATE:
    assert property ((o_ctrl.exz_en & ~(rail_q & ~ami_eff)) == RST_REG)
    else $error("excess zero enabled outside single rail zero-sub");

  AST_RXPD:
    assert property (wr_en && at_rxpd |=> o_ctrl.rx_pd == $past(i_req.wdata))
    else $error("receiver power-down not applied");

  AST_TXPD:
    assert property (wr_en && at_txpd |=> o_ctrl.tx_pd == $past(i_req.wdata))
    else $error("transmitter power-down not applied");

  AST_READ_CLEARS:
    assert property (rd_en && at_ail && (i_ais_det == ais_stat) |=>
                     o_irq == 1'b0)
    else $error("read did not clear latches");

  AST_IRQ_LEVEL:
    assert property (o_irq == (ail_lat != RST_REG))
    else $error("interrupt output not tracking latches");

  AST_T1_CRIT:
    assert property (!i_e1_mode |-> o_crit[0] == CRIT_T1231)
    else $error("t1 criteria not selected");

  AST_E1_ETSI:
    assert property (i_e1_mode && crit_q[0] |-> o_crit[0] == CRIT_ETSI)
    else $error("etsi criteria not selected");

  AST_E1_G775:
    assert property (i_e1_mode && !crit_q[7] |-> o_crit[7] == CRIT_G775)
    else $error("g775 criteria not selected");

  AST_LCODE_USED:
    assert property (!code_ovr |-> o_ctrl.ami == lcode_q)
    else $error("line code select not applied");

  AST_EXZ_OFF:
    assert property ((o_ctrl.exz_en & ~exz_q) == RST_REG)
    else $error("excess zero detect running while disabled");

  AST_CV_OFF:
    assert property ((o_ctrl.cv_en & cvdis_q) == RST_REG)
    else $error("violation detect running while disabled");

  AST_CV_T1:
    assert property (!i_e1_mode |-> o_ctrl.cv_en == RST_REG)
    else $error("violation detect running outside e1");

  AST_SEC_HIDDEN:
    assert property (wr_en && !is_sec && i_req.addr == OFF_RAIL |=> $stable(rail_q))
    else $error("secondary register written from another bank");

  AST_UNMAPPED_READ:
    assert property (rd_en && !is_pri && !is_sec && i_req.addr != OFF_BANK |=>
                     o_rdata == RST_REG)
    else $error("unmapped bank read not zero");

  AST_CH1_TEST:
    assert property (bank_q == BP_CHTEST[0] |-> o_bank == BANK_CHTEST &&
                     o_test_chan == 3'h0)
    else $error("channel 1 test bank not decoded");

  AST_STATUS_READ:
    assert property (rd_en && at_ais |=> o_rdata == $past(ais_stat))
    else $error("alarm status read wrong");

  AST_CE_FREEZE:
    assert property (!i_ce |=> $stable(bank_q) && $stable(o_rdata))
    else $error("state moved while clock enable low");

endmodule : olcr_regs
`default_nettype wire

//--- verilog/olcr_pkg.sv
`default_nettype none
package olcr_pkg;

  // ==========================================================
  // widths
  localparam int NCH = 8;
  typedef logic [7:0] olcr_byte_t;
  typedef logic [4:0] olcr_addr_t;

  // ==========================================================
  // register offsets (bank pointer reachable from every bank)
  localparam olcr_addr_t OFF_RAIL  = 5'h00;
  localparam olcr_addr_t OFF_LCODE = 5'h01;
  localparam olcr_addr_t OFF_RXPD  = 5'h03;
  localparam olcr_addr_t OFF_TXPD  = 5'h04;
  localparam olcr_addr_t OFF_EXZ   = 5'h05;
  localparam olcr_addr_t OFF_CVDIS = 5'h06;
  localparam olcr_addr_t OFF_CRIT  = 5'h0d;
  localparam olcr_addr_t OFF_GCFG  = 5'h0f;
  localparam olcr_addr_t OFF_FLOAT = 5'h12;
  localparam olcr_addr_t OFF_AIS   = 5'h13;
  localparam olcr_addr_t OFF_AIE   = 5'h14;
  localparam olcr_addr_t OFF_AIL   = 5'h15;
  localparam olcr_addr_t OFF_BANK  = 5'h1f;

  // ==========================================================
  // reset values and fields
  localparam olcr_byte_t RST_REG  = 8'h00;
  localparam olcr_byte_t ALL_ONES = 8'hff;
  localparam int         GCFG_CODE_BIT = 4;

  // ==========================================================
  // bank pointer codes
  localparam olcr_byte_t BP_PRI   = 8'h00;
  localparam olcr_byte_t BP_SEC   = 8'haa;
  localparam olcr_byte_t BP_IND   = 8'h01;
  localparam olcr_byte_t BP_BERT  = 8'h02;
  localparam olcr_byte_t BP_GTEST = 8'h03;
  localparam olcr_byte_t BP_CHTEST [NCH] = '{
    8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'ha0, 8'h0b
  };

  typedef enum logic [2:0] {
    BANK_PRI    = 3'b000,
    BANK_SEC    = 3'b001,
    BANK_IND    = 3'b010,
    BANK_BERT   = 3'b011,
    BANK_GTEST  = 3'b100,
    BANK_CHTEST = 3'b101,
    BANK_NONE   = 3'b110
  } olcr_bank_t;

  typedef enum logic [1:0] {
    CRIT_T1231 = 2'b00,
    CRIT_G775  = 2'b01,
    CRIT_ETSI  = 2'b10
  } olcr_crit_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    olcr_addr_t addr;
    olcr_byte_t wdata;
  } olcr_req_t;

  typedef struct packed {
    olcr_byte_t tx_float;
    olcr_byte_t single_rail;
    olcr_byte_t ami;
    olcr_byte_t rx_pd;
    olcr_byte_t tx_pd;
    olcr_byte_t exz_en;
    olcr_byte_t cv_en;
  } olcr_ctrl_t;

endpackage : olcr_pkg
`default_nettype wire

//--- verilog/olcr_alarm_chan.sv
`timescale 1ns/1ps
`default_nettype none
module olcr_alarm_chan
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_det,
  input  wire logic i_ie,
  input  wire logic i_clr,
  output logic      o_status,
  output logic      o_latch
);
  import olcr_pkg::*;

  logic status_q;
  logic latch_q;
  logic latch_d;
  wire  edge_seen = i_det ^ status_q;

  // ==========================================================
  // set wins over a clear in the same cycle
  assign latch_d = (edge_seen & i_ie) | (latch_q & ~i_clr);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      status_q <= 1'b0;
      latch_q  <= 1'b0;
    end
    else if (i_ce)
    begin
      status_q <= i_det;
      latch_q  <= latch_d;
    end
  end

  assign o_status = status_q;
  assign o_latch  = latch_q;

  // ==========================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_STATUS_FOLLOWS:
    assert property (i_ce |=> o_status == $past(i_det))
    else $error("status did not follow detector");
  AST_LATCH_ON_EDGE:
    assert property (i_ce && i_ie && (i_det != o_status) |=> o_latch)
    else $error("enabled transition not latched");
  AST_LATCH_MASKED:
    assert property (i_ce && !i_ie && !o_latch |=> !o_latch)
    else $error("latch set while disabled");
  AST_LATCH_CLEARED:
    assert property (i_ce && i_clr && (i_det == o_status) |=> !o_latch)
    else $error("latch not cleared");

endmodule : olcr_alarm_chan
`default_nettype wire

//--- bench/olcr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host processor on the control port
module olcr_host
(
  input  wire logic                 i_clk,
  output olcr_pkg::olcr_req_t       o_req,
  input  wire olcr_pkg::olcr_byte_t i_rdata
);
  import olcr_pkg::*;

  initial o_req = '0;

  // one request per call, held across the taking edge; an idle bus shows the
  // inverse of the last address and data so stale values never look valid
  task automatic xfer(input logic w, input olcr_addr_t a, input olcr_byte_t d,
                      output olcr_byte_t q);
    @(negedge i_clk);
    o_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge i_clk);
    q = i_rdata;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : olcr_host
`default_nettype wire

//--- bench/octal_liu_channel_control_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module octal_liu_channel_control_regs_bench;
  import olcr_pkg::*;

  logic             i_clk;
  logic             i_rst;
  logic             i_ce;
  logic             i_out_en;
  logic             i_e1_mode;
  olcr_byte_t       i_ais_det;
  olcr_req_t        req;
  olcr_byte_t       rdata;
  olcr_byte_t       q;
  olcr_byte_t       d;
  olcr_byte_t       ien;
  olcr_byte_t       hd;
  olcr_ctrl_t       ctrl;
  olcr_ctrl_t       g;
  olcr_crit_t [7:0] crit;
  olcr_bank_t       bank;
  logic [2:0]       tchan;
  logic             irq;
  int               mismatches = 0;
  int               samples_checked = 0;
  int               cycles = 0;
  olcr_byte_t       sv [6];
  olcr_byte_t       pv [3];
  olcr_addr_t       sec [6] = '{OFF_RAIL, OFF_LCODE, OFF_RXPD, OFF_TXPD, OFF_EXZ, OFF_CVDIS};
  olcr_addr_t       pa [3] = '{OFF_CRIT, OFF_GCFG, OFF_FLOAT};
  olcr_byte_t       codes [15] = '{8'h00, 8'haa, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                                   8'h06, 8'h07, 8'h08, 8'h09, 8'ha0, 8'h0b, 8'h0a, 8'ha9};

  olcr_regs dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req(req),
                   .i_out_en(i_out_en), .i_e1_mode(i_e1_mode), .i_ais_det(i_ais_det),
                   .o_rdata(rdata), .o_ctrl(ctrl), .o_crit(crit), .o_bank(bank),
                   .o_test_chan(tchan), .o_irq(irq));
  olcr_host host_u (.i_clk(i_clk), .o_req(req), .i_rdata(rdata));

  // ==========================================================
  // checking and expectations
  task automatic check_val(input string n, input logic [63:0] e, input logic [63:0] v);
    samples_checked++;
    if (v !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, v);
    end
  endtask : check_val

  task automatic wr(input olcr_addr_t a, input olcr_byte_t v);
    host_u.xfer(1'b1, a, v, q);
  endtask : wr

  task automatic rd_chk(input string n, input olcr_addr_t a, input olcr_byte_t e);
    host_u.xfer(1'b0, a, 8'h00, q);
    check_val(n, e, q);
  endtask : rd_chk

  // detectors run only in single rail without ami; t1 keeps violation detect off
  function automatic olcr_ctrl_t exp_ctrl();
    olcr_byte_t ami;
    ami = sv[1] | {8{pv[1][GCFG_CODE_BIT]}};
    exp_ctrl = '{tx_float: pv[2] | {8{~i_out_en}}, single_rail: sv[0], ami: ami,
                 rx_pd: sv[2], tx_pd: sv[3], exz_en: sv[4] & hd,
                 cv_en: ~sv[5] & hd & {8{i_e1_mode}}};
  endfunction : exp_ctrl

  function automatic logic [15:0] exp_crit();
    for (int i = 0; i < NCH; i++)
      exp_crit[2*i +: 2] = !i_e1_mode ? CRIT_T1231 : (pv[0][i] ? CRIT_ETSI : CRIT_G775);
  endfunction : exp_crit

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // ==========================================================
  // clock and hang guard
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_out_en = 1'b0;
    i_e1_mode = 1'b0;
    i_ais_det = 8'h00;
    void'($urandom(36));
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    check_val("reset controls", {8'hff, 48'h0}, ctrl);
    check_val("reset irq", 1'b0, irq);
    foreach (sec[k]) rd_chk("primary hides secondary", sec[k], 8'h00);
    wr(OFF_FLOAT, 8'ha5);
    for (int k = 0; k < 15; k++)
    begin
      wr(OFF_BANK, codes[k]);
      check_val("bank", olcr_bank_t'(k < 5 ? k : (k < 13 ? 5 : 6)), bank);
      check_val("test channel", (k > 4 && k < 13) ? k - 5 : 0, tchan);
      rd_chk("bank pointer", OFF_BANK, codes[k]);
      rd_chk("float outside bank", OFF_FLOAT, k == 0 ? 8'ha5 : 8'h00);
    end
    // a frozen clock enable must swallow the write
    i_ce = 1'b0;
    wr(OFF_BANK, BP_PRI);
    check_val("bank frozen", BANK_NONE, bank);
    i_ce = 1'b1;
    for (int n = 0; n < 16; n++)
    begin
      foreach (sv[k]) sv[k] = 8'($urandom);
      foreach (pv[k]) pv[k] = 8'($urandom);
      pv[1][GCFG_CODE_BIT] = n[0];
      i_out_en = 1'($urandom);
      i_e1_mode = 1'($urandom);
      wr(OFF_BANK, BP_SEC);
      foreach (sec[k]) wr(sec[k], sv[k]);
      foreach (sec[k]) rd_chk("secondary reg", sec[k], sv[k]);
      wr(OFF_BANK, BP_PRI);
      foreach (pa[k]) wr(pa[k], pv[k]);
      foreach (pa[k]) rd_chk("primary reg", pa[k], pv[k]);
      hd = sv[0] & ~(sv[1] | {8{pv[1][GCFG_CODE_BIT]}});
      g = ctrl;
      check_val("control outputs", exp_ctrl(), g);
      check_val("criteria", exp_crit(), crit);
    end
    // a reset in mid-run must bring every register back to zero
    i_rst = 1'b1;
    @(negedge i_clk);
    i_rst = 1'b0;
    check_val("reset bank again", BANK_PRI, bank);
    check_val("reset controls again", {{8{~i_out_en}}, 48'h0}, ctrl);
    check_val("reset read data", 8'h00, rdata);
    // ==========================================================
    // alarm status and latched interrupts
    d = 8'($urandom) | 8'h01;
    ien = 8'($urandom) | 8'h81;
    wr(OFF_AIE, ien);
    rd_chk("alarm enable", OFF_AIE, ien);
    wr(OFF_AIS, 8'hff);
    rd_chk("status read only", OFF_AIS, 8'h00);
    rd_chk("unmapped primary", OFF_RAIL, 8'h00);
    i_ais_det = d;
    repeat (2) @(negedge i_clk);
    check_val("irq raised", 1'b1, irq);
    rd_chk("status", OFF_AIS, d);
    rd_chk("latch on rise", OFF_AIL, d & ien);
    rd_chk("latch after read", OFF_AIL, 8'h00);
    check_val("irq cleared", 1'b0, irq);
    i_ais_det = 8'h00;
    repeat (2) @(negedge i_clk);
    rd_chk("latch on fall", OFF_AIL, d & ien);
    i_ais_det = 8'hff;
    repeat (2) @(negedge i_clk);
    wr(OFF_AIE, ien & 8'h0f);
    rd_chk("latch after disable", OFF_AIL, ien & 8'h0f);
    i_ais_det = 8'h00;
    repeat (2) @(negedge i_clk);
    rd_chk("latch masked", OFF_AIL, ien & 8'h0f);
    check_val("irq idle", 1'b0, irq);
    test_done();
  end
endmodule : octal_liu_channel_control_regs_bench
`default_nettype wire
